// ---- rtl/ifs_pkg.sv ----
// Purpose: Shared types and constants of the instruction fetch sequencer.
// Assumes: One system clock; program memory words are 16 bits wide.
// Notes:   Field positions, widths and multi-bit reset values live here; one-bit flags reset in their modules.

// ****************************************************************
// Package
// ****************************************************************
package ifs_pkg;

    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int STK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int LVL_W = 4;

    // Reset values and fixed addresses.
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [3:0] PHASE_OH_RESET = 4'h1;
    localparam logic [LVL_W-1:0] LVL_EMPTY = 4'h0;
    localparam logic [LVL_W-1:0] LVL_FULL = 4'h8;
    localparam logic [LVL_W-1:0] LVL_ONE = 4'h1;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [SP_W-1:0] SP_ONE = 3'h1;

    // Phases of one instruction cycle.
    typedef enum logic [1:0] {PH1, PH2, PH3, PH4} ifs_phase_t;

    // Instruction classes held in the top nibble of a word.
    typedef enum logic [3:0] {
        OP_NOP, OP_ALU, OP_SKZ, OP_JUMP, OP_CALL, OP_RETURN, OP_INTRET,
        OP_PCLW, OP_PCLR, OP_BANK, OP_EXT, OP_EI
    } ifs_op_t;

    // Arithmetic unit functions.
    typedef enum logic [3:0] {
        AF_ADD, AF_SUB, AF_AND, AF_OR, AF_XOR, AF_CPL,
        AF_RR, AF_RL, AF_INC, AF_DEC, AF_PASS
    } ifs_alu_t;

    // Instruction word layout: class, function, immediate.
    typedef struct packed {
        logic [3:0] op;
        logic [3:0] func;
        logic [7:0] imm;
    } ifs_word_t;

    // Full fetch address: bank bit above the counter.
    typedef struct packed {
        logic bank;
        logic [PC_W-1:0] pc;
    } ifs_addr_t;

    localparam ifs_word_t WORD_NOP = 16'h0000;

    // True for classes that load a new counter value.
    function automatic logic ifs_loads_pc(input ifs_op_t op);
        return op == OP_JUMP || op == OP_CALL || op == OP_RETURN ||
               op == OP_INTRET || op == OP_PCLW;
    endfunction

endpackage

// ---- rtl/ifs_alu.sv ----
// Purpose: Eight-bit arithmetic and logic unit of the sequencer.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Zero output drives the skip decision.

`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Arithmetic unit
// ****************************************************************
module ifs_alu
    import ifs_pkg::*;
(
    // Operands and function
    input wire logic [DATA_W-1:0] a,
    input wire logic [DATA_W-1:0] b,
    input wire logic [3:0] func,
    // Result
    output logic [DATA_W-1:0] result,
    output logic zero
);

    // One eight-bit datapath serves every arithmetic unit function.
    always_comb begin
        case (ifs_alu_t'(func))
            AF_ADD: result = a + b;
            AF_SUB: result = a - b;
            AF_AND: result = a & b;
            AF_OR: result = a | b;
            AF_XOR: result = a ^ b;
            AF_CPL: result = ~a;
            AF_RR: result = {a[0], a[DATA_W-1:1]};
            AF_RL: result = {a[DATA_W-2:0], a[DATA_W-1]};
            AF_INC: result = a + 8'h01;
            AF_DEC: result = a - 8'h01;
            AF_PASS: result = b;
            default: result = a;
        endcase
    end

    // Branch decision flag.
    assign zero = (result == 8'h00);

endmodule // ifs_alu

`default_nettype wire

// ---- rtl/ifs_sequencer.sv ----
// Purpose: Four-phase instruction fetch and execute sequencer.
// Assumes: Program memory answers a fetch within three clocks.
// Notes:   Fetch of the next word overlaps execution of this one.

`timescale 1ns/1ns
`default_nettype none

module ifs_sequencer
    import ifs_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Program memory fetch port
    output ifs_addr_t FETCH_ADDR,
    output logic FETCH_REQ,
    input wire ifs_word_t FETCH_DATA,
    // Interrupt request and acknowledge
    input wire logic IRQ_REQ,
    output logic IRQ_ACK,
    output logic IRQ_PENDING,
    // Observation of state
    output logic [3:0] PHASE,
    output logic [DATA_W-1:0] ACC,
    output logic [DATA_W-1:0] PC_LOW,
    output logic STACK_FULL
);

    // ************************************************************
    // Declarations
    // ************************************************************
    ifs_phase_t phase_r;
    logic [3:0] phase_oh_r;
    ifs_addr_t pc_r;
    ifs_addr_t ir_pc_r;
    ifs_word_t ir_r;
    ifs_op_t op_r;
    logic code_bank_select_bit_r;
    logic [DATA_W-1:0] acc_r;
    logic [DATA_W-1:0] acc_nxt;
    logic [DATA_W-1:0] alu_res;
    logic alu_zero;
    logic [DATA_W-1:0] alu_res_r;
    logic alu_zero_r;
    logic ext_r;
    logic fetch_req_r;
    logic irq_ack_r;
    logic pend_r;
    logic emi_r;
    ifs_addr_t stk [STK_DEPTH];
    logic [SP_W-1:0] sp_r;
    logic [LVL_W-1:0] lvl_r;
    ifs_addr_t stk_top;
    logic cycle_end;
    logic redirect;
    logic flush;
    logic stall;
    logic push;
    logic pop;
    logic ack;
    logic acc_we;
    logic emi_set;
    ifs_addr_t target;
    ifs_addr_t push_val;
    ifs_addr_t launch;

    // ************************************************************
    // Phase generator
    // ************************************************************

    // Four phases rotate; the one-hot copy never has two bits set.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            phase_r <= PH1;
            phase_oh_r <= PHASE_OH_RESET;
        end else begin
            case (phase_r)
                PH1: phase_r <= PH2;
                PH2: phase_r <= PH3;
                PH3: phase_r <= PH4;
                PH4: phase_r <= PH1;
                default: phase_r <= PH1;
            endcase
            phase_oh_r <= {phase_oh_r[2:0], phase_oh_r[3]};
        end
    end

    assign cycle_end = (phase_r == PH4);

    // ************************************************************
    // Decode and execute
    // ************************************************************

    // Decode at the end of phase two, compute at the end of phase three.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            op_r <= OP_NOP;
            alu_res_r <= ACC_RESET;
            alu_zero_r <= 1'b0;
        end else begin
            if (phase_r == PH2) begin
                op_r <= ifs_op_t'(ir_r.op);
            end
            if (phase_r == PH3) begin
                alu_res_r <= alu_res;
                alu_zero_r <= alu_zero;
            end
        end
    end

    // Accumulator and immediate feed the arithmetic unit.
    ifs_alu u_alu (
        .a(acc_r),
        .b(ir_r.imm),
        .func(ir_r.func),
        .result(alu_res),
        .zero(alu_zero)
    );

    assign stk_top = stk[sp_r - SP_ONE];
    assign launch = redirect ? target : {pc_r.bank, pc_r.pc + PC_ONE};

    // Sequencing decisions taken in phase four of the current cycle.
    always_comb begin
        redirect = 1'b0;
        flush = 1'b0;
        stall = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        ack = 1'b0;
        acc_we = 1'b0;
        emi_set = 1'b0;
        acc_nxt = alu_res_r;
        target = {code_bank_select_bit_r, ir_pc_r.pc[PC_W-1], ir_r.func,
                  ir_r.imm};
        push_val = {ir_pc_r.bank, ir_pc_r.pc + PC_ONE};
        case (op_r)
            OP_ALU: acc_we = 1'b1;
            OP_SKZ: begin
                acc_we = 1'b1;
                flush = alu_zero_r;
            end
            OP_CALL: push = 1'b1;
            OP_RETURN: begin
                pop = 1'b1;
                target = stk_top;
            end
            OP_INTRET: begin
                pop = 1'b1;
                emi_set = 1'b1;
                target = stk_top;
            end
            OP_PCLW: target = {ir_pc_r.bank, ir_pc_r.pc[PC_W-1:DATA_W],
                               acc_r};
            OP_PCLR: begin
                acc_we = 1'b1;
                acc_nxt = ir_pc_r.pc[DATA_W-1:0];
            end
            OP_EXT: begin
                stall = !ext_r;
                acc_we = ext_r;
            end
            OP_EI: emi_set = 1'b1;
            default: acc_we = 1'b0;
        endcase
        redirect = ifs_loads_pc(op_r);
        // Interrupt takes the slot of the prefetched word when room exists.
        if (pend_r && emi_r && !redirect && !flush && !stall &&
            lvl_r != LVL_FULL) begin
            ack = 1'b1;
            redirect = 1'b1;
            push = 1'b1;
            push_val = pc_r;
            target = {pc_r.bank, INT_VECTOR};
        end
    end

    // ************************************************************
    // Program counter and fetch
    // ************************************************************

    // A new fetch launches so that it stands through phase one.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pc_r <= {1'b0, PC_RESET};
            ir_pc_r <= {1'b0, PC_RESET};
            ir_r <= WORD_NOP;
            fetch_req_r <= 1'b1;
            ext_r <= 1'b0;
        end else begin
            fetch_req_r <= cycle_end && !stall;
            if (cycle_end) begin
                ext_r <= stall;
                if (!stall) begin
                    pc_r <= launch;
                    ir_pc_r <= pc_r;
                    // Branches and met skips replace the prefetch by a dummy.
                    ir_r <= (redirect || flush) ? WORD_NOP
                                                : FETCH_DATA;
                end
            end
        end
    end

    // Bank bit and accumulator writeback.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            code_bank_select_bit_r <= 1'b0;
            acc_r <= ACC_RESET;
        end else if (cycle_end) begin
            if (op_r == OP_BANK) begin
                code_bank_select_bit_r <= ir_r.imm[0];
            end
            if (acc_we) begin
                acc_r <= acc_nxt;
            end
        end
    end

    // ************************************************************
    // Return stack and interrupt
    // ************************************************************

    // Circular stack; a push when full overwrites the oldest entry.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sp_r <= SP_RESET;
            lvl_r <= LVL_EMPTY;
        end else if (cycle_end && push) begin
            stk[sp_r] <= push_val;
            sp_r <= sp_r + SP_ONE;
            if (lvl_r != LVL_FULL) begin
                lvl_r <= lvl_r + LVL_ONE;
            end
        end else if (cycle_end && pop) begin
            sp_r <= sp_r - SP_ONE;
            if (lvl_r != LVL_EMPTY) begin
                lvl_r <= lvl_r - LVL_ONE;
            end
        end
    end

    // Request flag: a new request wins over the clearing acknowledge.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pend_r <= 1'b0;
            emi_r <= 1'b0;
            irq_ack_r <= 1'b0;
        end else begin
            pend_r <= IRQ_REQ || (pend_r && !(cycle_end && ack));
            irq_ack_r <= cycle_end && ack;
            if (cycle_end && ack) begin
                emi_r <= 1'b0;
            end else if (cycle_end && emi_set) begin
                emi_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign FETCH_ADDR = pc_r;
    assign FETCH_REQ = fetch_req_r;
    assign IRQ_ACK = irq_ack_r;
    assign IRQ_PENDING = pend_r;
    assign PHASE = phase_oh_r;
    assign ACC = acc_r;
    assign PC_LOW = pc_r.pc[DATA_W-1:0];
    assign STACK_FULL = (lvl_r == LVL_FULL);

    // ************************************************************
    // Checks
    // ************************************************************
    phase_onehot_a: assert property (
        @(posedge CLK) disable iff (RESET) $onehot(PHASE))
        else $error("phase outputs not one-hot");

    phase_walk_a: assert property (
        @(posedge CLK) disable iff (RESET)
        phase_r == PH1 |=> phase_r == PH2 ##1 phase_r == PH3
        ##1 phase_r == PH4 ##1 phase_r == PH1)
        else $error("phase sequence broken");

    fetch_phase_a: assert property (
        @(posedge CLK) disable iff (RESET)
        FETCH_REQ |-> phase_r == PH1 && PHASE == PHASE_OH_RESET)
        else $error("fetch outside phase one");

    pc_step_a: assert property (
        @(posedge CLK) disable iff (RESET)
        cycle_end && !stall && !redirect
        |=> FETCH_ADDR.pc - $past(FETCH_ADDR.pc) == PC_ONE && FETCH_REQ)
        else $error("counter did not advance by one");

    branch_dummy_a: assert property (
        @(posedge CLK) disable iff (RESET)
        cycle_end && redirect |=> (ir_r == WORD_NOP) [*4])
        else $error("no dummy cycle after branch");

    skip_flush_a: assert property (
        @(posedge CLK) disable iff (RESET)
        cycle_end && op_r == OP_SKZ && alu_zero_r && !ext_r
        |=> ir_r == WORD_NOP)
        else $error("skip kept prefetched word");

    pcl_page_a: assert property (
        @(posedge CLK) disable iff (RESET)
        cycle_end && op_r == OP_PCLW
        |=> FETCH_ADDR.pc[PC_W-1:DATA_W] == $past(ir_pc_r.pc[PC_W-1:DATA_W])
        && FETCH_ADDR.pc[DATA_W-1:0] == $past(acc_r))
        else $error("low byte write left page");

    full_no_ack_a: assert property (
        @(posedge CLK) disable iff (RESET)
        cycle_end && lvl_r == LVL_FULL |=> !IRQ_ACK)
        else $error("interrupt acknowledged with full stack");

    call_push_a: assert property (
        @(posedge CLK) disable iff (RESET)
        cycle_end && op_r == OP_CALL && lvl_r != LVL_FULL
        |=> lvl_r == $past(lvl_r) + LVL_ONE)
        else $error("call did not push");

    ext_stall_a: assert property (
        @(posedge CLK) disable iff (RESET)
        cycle_end && op_r == OP_EXT && !ext_r |=> !FETCH_REQ [*4])
        else $error("extended instruction did not hold fetch");

endmodule // ifs_sequencer

`default_nettype wire

// ---- bench/ifs_prog_mem.sv ----
// Purpose: Program memory model answering the sequencer's fetches.
// Assumes: One clock; the sequencer samples the word at its PH4 edge.
// Notes:   Slow mode shows a scrambled word until three cycles later.

`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Program memory model
// ****************************************************************
module ifs_prog_mem
    import ifs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fetch port
    input wire ifs_addr_t fetch_addr,
    input wire logic fetch_req,
    output var ifs_word_t fetch_data,
    // Response speed select
    input wire logic slow
);
    ifs_word_t mem [0:16383];
    logic [1:0] wait_r;

    // Counts down the access time after each request in slow mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_r <= 2'h0;
        end else if (fetch_req && slow) begin
            wait_r <= 2'h2;
        end else if (wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
        end
    end

    // A word not yet ready shows inverted, so it never looks valid.
    always_comb begin
        fetch_data = mem[fetch_addr];
        if (slow && (fetch_req || wait_r != 2'h0)) begin
            fetch_data = ~mem[fetch_addr];
        end
    end
endmodule // ifs_prog_mem

`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench of the instruction fetch sequencer.
// Assumes: Programs are placed straight into the memory model.
// Notes:   A monitor logs every fetch address with its clock count.

`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Testbench
// ****************************************************************
module testbench
    import ifs_pkg::*;
;
    localparam int LIMIT = 5000;
    logic CLK, RESET, IRQ_REQ, slow, ack_seen;
    logic FETCH_REQ, IRQ_ACK, IRQ_PENDING, STACK_FULL;
    ifs_addr_t FETCH_ADDR;
    ifs_word_t FETCH_DATA;
    logic [3:0] PHASE;
    logic [DATA_W-1:0] ACC, PC_LOW;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [13:0] fa [$];
    int ft [$];

    ifs_sequencer i_ifs_sequencer (.CLK(CLK), .RESET(RESET),
        .FETCH_ADDR(FETCH_ADDR), .FETCH_REQ(FETCH_REQ),
        .FETCH_DATA(FETCH_DATA), .IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK),
        .IRQ_PENDING(IRQ_PENDING), .PHASE(PHASE), .ACC(ACC),
        .PC_LOW(PC_LOW), .STACK_FULL(STACK_FULL));
    ifs_prog_mem i_ifs_prog_mem (.clk(CLK), .rst(RESET),
        .fetch_addr(FETCH_ADDR), .fetch_req(FETCH_REQ),
        .fetch_data(FETCH_DATA), .slow(slow));

    // Counts and reports one comparison.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Free-running clock of 100 ns.
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Logs each fetch once, watches acknowledges and cuts a hang short.
    always @(posedge CLK) begin
        cyc++;
        if (RESET) begin
            fa.delete();
            ft.delete();
            ack_seen = 1'b0;
        end else begin
            if (IRQ_ACK === 1'b1) ack_seen = 1'b1;
            if (FETCH_REQ === 1'b1 && (ft.size() == 0 || ft[$] != cyc - 1)) begin
                fa.push_back(FETCH_ADDR);
                ft.push_back(cyc);
                check(16'(PC_LOW), 16'(FETCH_ADDR.pc[7:0]));
            end
        end
        if (cyc == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end

    // Expected accumulator after one arithmetic unit function.
    function automatic logic [7:0] alu_ref(input logic [3:0] f,
        input logic [7:0] a, input logic [7:0] b);
        case (f)
            4'h0: return a + b;
            4'h1: return a - b;
            4'h2: return a & b;
            4'h3: return a | b;
            4'h4: return a ^ b;
            4'h5: return ~a;
            4'h6: return {a[0], a[7:1]};
            4'h7: return {a[6:0], a[7]};
            4'h8: return a + 8'h01;
            4'h9: return a - 8'h01;
            default: return b;
        endcase
    endfunction

    // Enters reset and fills the memory with no-operation words.
    task automatic start(input logic s);
        @(posedge CLK);
        RESET <= 1'b1;
        IRQ_REQ <= 1'b0;
        slow <= s;
        foreach (i_ifs_prog_mem.mem[a]) i_ifs_prog_mem.mem[a] = WORD_NOP;
    endtask

    // Places one word into program memory.
    task automatic poke(input int a, input logic [15:0] w);
        i_ifs_prog_mem.mem[a] = w;
    endtask

    // Holds reset six cycles, releases it and runs n cycles.
    task automatic go(input int n);
        repeat (6) @(posedge CLK);
        RESET <= 1'b0;
        repeat (n) @(posedge CLK);
    endtask

    // Straight-line code: phase rotation, fetch pulse and spacing.
    // Runs long enough that seven fetches are logged before the checks.
    task automatic t_seq(input logic s);
        logic [3:0] p;
        start(s);
        go(16);
        @(negedge CLK);
        for (int i = 0; i < 12; i++) begin
            p = PHASE;
            check(16'(FETCH_REQ), 16'(p == 4'h1));
            @(negedge CLK);
            check(16'(PHASE), 16'({p[2:0], p[3]}));
        end
        for (int i = 0; i < 6; i++) begin
            check(16'(fa[i]), 16'(i));
            check(16'(ft[i + 1] - ft[i]), 16'h0004);
        end
    endtask

    // One arithmetic function applied to the accumulator.
    task automatic t_alu(input int f);
        start(1'b0);
        poke(0, 16'h1a96);
        poke(1, {4'h1, 4'(f), 8'h3c});
        go(40);
        check(16'(ACC), 16'(alu_ref(4'(f), 8'h96, 8'h3c)));
    endtask

    // Jump, call and return, each followed by a refetch.
    task automatic t_branch;
        logic [13:0] e [8] = '{14'h0000, 14'h0001, 14'h0123, 14'h0124,
            14'h0040, 14'h0041, 14'h0124, 14'h0125};
        start(1'b1);
        poke(0, 16'h3123);
        poke(14'h123, 16'h4040);
        poke(14'h40, 16'h5000);
        go(40);
        foreach (e[i]) check(16'(fa[i]), 16'(e[i]));
        check(16'(ft[7] - ft[0]), 16'h001c);
    endtask

    // Skip taken on a zero result, not taken otherwise.
    task automatic t_skip(input logic [7:0] v, input logic [7:0] r);
        start(1'b0);
        poke(0, 16'h1a10);
        poke(1, {8'h21, v});
        poke(2, 16'h1a77);
        go(32);
        check(16'(ACC), 16'(r));
        check(16'(fa[4]), 16'h0004);
    endtask

    // Low byte write jumps in its page; low byte read gives own address.
    task automatic t_pcl;
        start(1'b0);
        poke(0, 16'h31f0);
        poke(14'h1f0, 16'h1a35);
        poke(14'h1f1, 16'h7000);
        poke(14'h136, 16'h8000);
        go(48);
        check(16'(fa[4]), 16'h01f2);
        check(16'(fa[5]), 16'h0135);
        check(16'(ACC), 16'h0036);
    endtask

    // Bank bit lands above the counter on a jump target.
    task automatic t_bank;
        start(1'b1);
        poke(0, 16'h9001);
        poke(1, 16'h3050);
        go(32);
        check(16'(fa[0]), 16'h0000);
        check(16'(fa[3]), 16'h2050);
    endtask

    // Extended instruction holds the next fetch for one more cycle.
    task automatic t_ext;
        start(1'b0);
        poke(0, 16'haa11);
        go(40);
        check(16'(ft[1] - ft[0]), 16'h0004);
        check(16'(ft[2] - ft[1]), 16'h0008);
        check(16'(fa[2]), 16'h0002);
        check(16'(ACC), 16'h0011);
    endtask

    // Eight nested calls fill the stack; an interrupt waits for a return.
    task automatic t_full;
        int n;
        start(1'b1);
        poke(0, 16'hb000);
        poke(1, 16'h4010);
        for (int k = 1; k < 8; k++) poke(k * 16, {8'h40, 8'(k * 16 + 16)});
        poke(14'h90, 16'h5000);
        go(1);
        n = 0;
        while (STACK_FULL !== 1'b1 && n < 200) begin
            @(posedge CLK);
            n++;
        end
        check(16'(STACK_FULL), 16'h0001);
        IRQ_REQ <= 1'b1;
        @(posedge CLK);
        IRQ_REQ <= 1'b0;
        repeat (20) @(posedge CLK);
        check(16'(IRQ_PENDING), 16'h0001);
        check(16'(ack_seen), 16'h0000);
        n = 0;
        while (IRQ_ACK !== 1'b1 && n < 200) begin
            @(negedge CLK);
            n++;
        end
        check(16'(FETCH_ADDR), 16'h0004);
        check(16'(IRQ_PENDING), 16'h0000);
    endtask

    // Main sequence.
    initial begin
        RESET = 1'b1;
        IRQ_REQ = 1'b0;
        slow = 1'b0;
        ack_seen = 1'b0;
        t_seq(1'b0);
        t_seq(1'b1);
        for (int f = 0; f < 11; f++) t_alu(f);
        t_branch();
        t_skip(8'h10, 8'h00);
        t_skip(8'h0f, 8'h77);
        t_pcl();
        t_bank();
        t_ext();
        t_full();
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
